// file: verilog/radio_fsm_cfg.svh
`ifndef RADIO_FSM_CFG_SVH
`define RADIO_FSM_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_CFG_TWO     6'h16
`define ADDR_CFG_ONE     6'h17
`define ADDR_CFG_ZERO    6'h18

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CFG_TWO      8'h07
`define RST_CLR_SEL      2'h3
`define RST_RX_NEXT      2'h0
`define RST_TX_NEXT      2'h0
`define RST_CAL_POLICY   2'h0
`define RST_PO_SEL       2'h1
`define RST_SPARE        1'h0
`define RST_FORCE_ON     1'h0

// ****************************************************************
// Field positions
// ****************************************************************
`define CFG_TWO_MASK     8'h1f
`define CLR_HI           5
`define CLR_LO           4
`define RXN_HI           3
`define RXN_LO           2
`define TXN_HI           1
`define TXN_LO           0
`define CAL_HI           5
`define CAL_LO           4
`define PO_HI            3
`define PO_LO            2
`define SPARE_BIT        1
`define FORCE_BIT        0

// ****************************************************************
// Power-up timing
// ****************************************************************
`define RIPPLE_LAST      6'h3f
`define EXPIRE_SEL0      9'h001
`define EXPIRE_SEL1      9'h010
`define EXPIRE_SEL2      9'h040
`define EXPIRE_SEL3      9'h100
`define AUTO_CAL_LAST    2'h3

`endif

// file: verilog/radio_fsm_pkg.sv
`default_nettype none
package radio_fsm_pkg;

    // Operating states of the main radio state machine
    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_SYNTH_TX = 2'b01,
        ST_TX       = 2'b10,
        ST_RX       = 2'b11
    } radio_state_t;

    // Clear channel selection modes
    typedef enum logic [1:0] {
        CLR_ALWAYS   = 2'b00,
        CLR_RSSI     = 2'b01,
        CLR_NO_PKT   = 2'b10,
        CLR_BOTH     = 2'b11
    } clr_mode_t;

    // Synthesizer calibration policies
    typedef enum logic [1:0] {
        CAL_MANUAL   = 2'b00,
        CAL_LEAVE    = 2'b01,
        CAL_RETURN   = 2'b10,
        CAL_FOURTH   = 2'b11
    } cal_policy_t;

    // Power-up timer state
    typedef struct packed {
        logic [5:0] ripple;
        logic [8:0] expiries;
        logic       done;
    } timer_state_t;

    // Configuration and control state
    typedef struct packed {
        logic [7:0]   cfg_two;
        clr_mode_t    clear_channel_select;
        logic [1:0]   after_receive_next_state;
        logic [1:0]   after_transmit_next_state;
        cal_policy_t  synth_calibration_policy;
        logic [1:0]   powerup_expiry_count;
        logic         spare;
        logic         force_osc_on;
        logic [7:0]   rdata;
        logic         clear_channel_flag;
        logic         next_valid;
        radio_state_t next_state;
        logic         cal_start;
        logic [1:0]   auto_returns;
    } cfg_state_t;

endpackage
`default_nettype wire

// file: verilog/powerup_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "radio_fsm_cfg.svh"

module powerup_timer
    import radio_fsm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       settled,
    input  wire logic [1:0] expire_sel,
    output logic            done
);

    timer_state_t st;
    timer_state_t next_st;
    logic [8:0]   target;

    // ************************************************************
    // Expiry target
    // ************************************************************
    always_comb
    begin
        unique case (expire_sel)
            2'h0: target = `EXPIRE_SEL0;
            2'h1: target = `EXPIRE_SEL1;
            2'h2: target = `EXPIRE_SEL2;
            2'h3: target = `EXPIRE_SEL3;
        endcase
    end

    // ************************************************************
    // Six-bit ripple counter and expiry count
    // ************************************************************
    // Restarts whenever the oscillator drops out of its settled state
    always_comb
    begin
        next_st = st;
        if (!settled)
        begin
            next_st = '0;
        end
        else if (!st.done)
        begin
            next_st.ripple = st.ripple + 6'h01;
            if (st.ripple == `RIPPLE_LAST)
            begin
                next_st.expiries = st.expiries + 9'h001;
                if ((st.expiries + 9'h001) >= target)
                    next_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            st <= '0;
        else
            st <= next_st;
    end

    assign done = st.done;

endmodule
`default_nettype wire

// file: verilog/radio_state_config.sv
// Contract
// - Clear channel flag follows 2-bit mode: always, RSSI low, no packet, both.
// - After receive go to idle, synth-on, transmit or stay receiving; resets 0.
// - After transmit go to idle, synth-on, stay transmitting, or receive; resets 0.
// - Calibrate manually, leaving idle, on auto return, or every fourth auto return.
// - Chip ready held off until ripple counter expires selected times; field resets 1.
// - Timeout setting 0..3 selects 1, 16, 64 or 256 expiries.
// - Oscillator-stable asserts together with chip ready, no delay between them.
// - Force bit keeps oscillator on during sleep; resets 0.
`timescale 1ns/1ns
`default_nettype none
`include "radio_fsm_cfg.svh"

module radio_state_config
    import radio_fsm_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST_B,
    // Register port
    input  wire logic [5:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WRITE,
    output logic      [7:0] REG_RDATA,
    // Clear channel inputs and result
    input  wire logic       RSSI_BELOW,
    input  wire logic       RX_PACKET,
    output logic            CLEAR_CHANNEL_FLAG,
    // Packet completion and next state
    input  wire logic       RX_DONE,
    input  wire logic       TX_DONE,
    output logic            NEXT_VALID,
    output logic      [1:0] NEXT_STATE,
    // Calibration
    input  wire logic       CALIBRATE_STROBE,
    input  wire logic       LEAVE_IDLE,
    input  wire logic       AUTO_IDLE,
    output logic            CAL_START,
    // Oscillator and chip ready
    input  wire logic       XOSC_SETTLED,
    output logic            CHIP_READY_LOW,
    output logic            XOSC_STABLE,
    output logic            XOSC_KEEP_ON
);

    cfg_state_t st;
    cfg_state_t next_st;
    logic       timer_done;
    logic       wr_one;
    logic       wr_two;
    logic       wr_zero;
    logic       rssi_ok;
    logic       pkt_ok;
    logic       auto_cal;

    // ************************************************************
    // Power-up timeout
    // ************************************************************
    // The timer restarts whenever the oscillator drops out of its
    // settled state. A new timeout setting only takes effect at the
    // next expiry, since the target is compared only as the ripple
    // counter wraps; the compare is greater-or-equal, so a lowered setting never skips an expiry
    powerup_timer powerup_timer_inst (
        .clk        (CLK),
        .rst_b      (RST_B),
        .settled    (XOSC_SETTLED),
        .expire_sel (st.powerup_expiry_count),
        .done       (timer_done)
    );

    // ************************************************************
    // Register decode
    // ************************************************************
    // Writes to any other address fall through and are dropped,
    // so a stray host access cannot disturb the stored fields
    assign wr_two  = REG_WRITE && (REG_ADDR == `ADDR_CFG_TWO);
    assign wr_one  = REG_WRITE && (REG_ADDR == `ADDR_CFG_ONE);
    assign wr_zero = REG_WRITE && (REG_ADDR == `ADDR_CFG_ZERO);

    // Channel condition terms; the pins are taken as synchronous,
    // and the flag costs one cycle of lag so that it leaves a flop
    assign rssi_ok = RSSI_BELOW;
    assign pkt_ok  = !RX_PACKET;

    // ************************************************************
    // Automatic calibration decision
    // ************************************************************
    always_comb
    begin
        // Return counter is only kept under the every-fourth policy, so
        // a later switch back to it always starts counting afresh
        unique case (st.synth_calibration_policy)
            CAL_MANUAL: auto_cal = 1'b0;
            CAL_LEAVE:  auto_cal = LEAVE_IDLE;
            CAL_RETURN: auto_cal = AUTO_IDLE;
            CAL_FOURTH: auto_cal = AUTO_IDLE &&
                                   (st.auto_returns == `AUTO_CAL_LAST);
        endcase
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        next_st = st;

        // Register writes; reserved bits are not stored
        if (wr_two)
            next_st.cfg_two = REG_WDATA & `CFG_TWO_MASK;
        if (wr_one)
        begin
            next_st.clear_channel_select      = clr_mode_t'(REG_WDATA[`CLR_HI:`CLR_LO]);
            next_st.after_receive_next_state  = REG_WDATA[`RXN_HI:`RXN_LO];
            next_st.after_transmit_next_state = REG_WDATA[`TXN_HI:`TXN_LO];
        end
        // Bit 1 here is plain storage with no behaviour behind it
        if (wr_zero)
        begin
            next_st.synth_calibration_policy =
                cal_policy_t'(REG_WDATA[`CAL_HI:`CAL_LO]);
            next_st.powerup_expiry_count = REG_WDATA[`PO_HI:`PO_LO];
            next_st.spare                = REG_WDATA[`SPARE_BIT];
            next_st.force_osc_on         = REG_WDATA[`FORCE_BIT];
        end

        // Read data registered one cycle after the address; reserved
        // bits and unmapped places read back as zero
        next_st.rdata = 8'h00;
        unique case (REG_ADDR)
            `ADDR_CFG_TWO:
                next_st.rdata = st.cfg_two;
            `ADDR_CFG_ONE:
            begin
                next_st.rdata[`CLR_HI:`CLR_LO] = st.clear_channel_select;
                next_st.rdata[`RXN_HI:`RXN_LO] = st.after_receive_next_state;
                next_st.rdata[`TXN_HI:`TXN_LO] = st.after_transmit_next_state;
            end
            `ADDR_CFG_ZERO:
            begin
                next_st.rdata[`CAL_HI:`CAL_LO] = st.synth_calibration_policy;
                next_st.rdata[`PO_HI:`PO_LO]   = st.powerup_expiry_count;
                next_st.rdata[`SPARE_BIT]      = st.spare;
                next_st.rdata[`FORCE_BIT]      = st.force_osc_on;
            end
            default:
                next_st.rdata = 8'h00;
        endcase

        // Clear channel indication from the selected mode
        unique case (st.clear_channel_select)
            CLR_ALWAYS: next_st.clear_channel_flag = 1'b1;
            CLR_RSSI:   next_st.clear_channel_flag = rssi_ok;
            CLR_NO_PKT: next_st.clear_channel_flag = pkt_ok;
            CLR_BOTH:   next_st.clear_channel_flag = rssi_ok && pkt_ok;
        endcase

        // Next operating state; receive completion wins a tie since
        // both cannot legally finish together
        next_st.next_valid = RX_DONE || TX_DONE;
        // State output holds its last value between completions, so a
        // consumer that samples late still sees the last choice
        if (RX_DONE)
        begin
            next_st.next_state = radio_state_t'(st.after_receive_next_state);
        end
        else if (TX_DONE)
        begin
            next_st.next_state = radio_state_t'(st.after_transmit_next_state);
        end

        // Count automatic returns only under the every-fourth policy
        if (st.synth_calibration_policy != CAL_FOURTH)
            next_st.auto_returns = 2'h0;
        else if (AUTO_IDLE)
            next_st.auto_returns = st.auto_returns + 2'h1;

        // Manual strobe always calibrates, whatever the policy
        next_st.cal_start = CALIBRATE_STROBE || auto_cal;
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Whole struct cleared first, then the field reset values laid
    // over it; reset is synchronous, so only constants appear here
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            st                           <= '0;
            st.cfg_two                   <= `RST_CFG_TWO;
            st.clear_channel_select      <= clr_mode_t'(`RST_CLR_SEL);
            st.after_receive_next_state  <= `RST_RX_NEXT;
            st.after_transmit_next_state <= `RST_TX_NEXT;
            st.synth_calibration_policy  <= cal_policy_t'(`RST_CAL_POLICY);
            st.powerup_expiry_count      <= `RST_PO_SEL;
            st.spare                     <= `RST_SPARE;
            st.force_osc_on              <= `RST_FORCE_ON;
            st.next_state                <= ST_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign REG_RDATA          = st.rdata;
    assign CLEAR_CHANNEL_FLAG = st.clear_channel_flag;
    assign NEXT_VALID         = st.next_valid;
    assign NEXT_STATE         = st.next_state;
    assign CAL_START          = st.cal_start;
    // Both taken from the same flop so they cannot skew; ready is
    // active low and stays high until the selected expiry count
    assign CHIP_READY_LOW     = !timer_done;
    assign XOSC_STABLE        = timer_done;
    assign XOSC_KEEP_ON       = st.force_osc_on;

endmodule
`default_nettype wire

// file: sim/radio_state_config_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Port checker
// ********
module radio_state_config_checker
(
    input wire logic       CLK,
    input wire logic       RST_B,
    input wire logic [5:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WRITE,
    input wire logic       RSSI_BELOW,
    input wire logic       RX_PACKET,
    input wire logic       CLEAR_CHANNEL_FLAG,
    input wire logic       RX_DONE,
    input wire logic       TX_DONE,
    input wire logic       NEXT_VALID,
    input wire logic [1:0] NEXT_STATE,
    input wire logic       CALIBRATE_STROBE,
    input wire logic       LEAVE_IDLE,
    input wire logic       AUTO_IDLE,
    input wire logic       CAL_START,
    input wire logic       XOSC_SETTLED,
    input wire logic       CHIP_READY_LOW,
    input wire logic       XOSC_STABLE,
    input wire logic       XOSC_KEEP_ON
);
    logic [5:0]  one;
    logic [5:0]  zero;
    logic [1:0]  acnt;
    logic [15:0] scnt;
    logic [15:0] tgt;

    // Shadow of the control bytes, rebuilt from the write port
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            one <= 6'h30;
            zero <= 6'h04;
        end
        else if (REG_WRITE && REG_ADDR == 6'h17)
            one <= REG_WDATA[5:0];
        else if (REG_WRITE && REG_ADDR == 6'h18)
            zero <= REG_WDATA[5:0];
    end
    // Return count only lives in policy 3; settled cycles restart on drop
    always_ff @(posedge CLK)
    begin
        acnt <= (!RST_B || zero[5:4] != 2'h3) ? 2'h0 : acnt + 2'(AUTO_IDLE);
        scnt <= (!RST_B || !XOSC_SETTLED) ? 16'h0 : scnt + 16'h1;
    end
    // Wait in cycles, 64 per expiry
    assign tgt = zero[3:2] == 2'h0 ? 16'h0040 : zero[3:2] == 2'h1 ? 16'h0400 :
                 zero[3:2] == 2'h2 ? 16'h1000 : 16'h4000;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);

    AST_CLR: assert property ($past(RST_B) && $stable(one) |-> CLEAR_CHANNEL_FLAG ==
        ((!$past(one[4]) || $past(RSSI_BELOW)) && (!$past(one[5]) || !$past(RX_PACKET))))
        else $error("clear flag disagrees with mode");
    AST_RX_NEXT: assert property ($past(RST_B && RX_DONE) |->
        NEXT_VALID && NEXT_STATE == $past(one[3:2])) else $error("bad state after receive");
    AST_TX_NEXT: assert property ($past(RST_B && TX_DONE && !RX_DONE) |->
        NEXT_VALID && NEXT_STATE == $past(one[1:0])) else $error("bad state after send");
    AST_NEXT_CAUSE: assert property (NEXT_VALID |-> $past(RX_DONE || TX_DONE))
        else $error("next state without a finished packet");
    AST_CAL: assert property ($past(RST_B) |-> CAL_START == $past(CALIBRATE_STROBE ||
        LEAVE_IDLE && zero[5:4] == 2'h1 || AUTO_IDLE && (zero[5:4] == 2'h2 ||
        zero[5:4] == 2'h3 && acnt == 2'h3))) else $error("calibration start wrong");
    AST_SAME: assert property (CHIP_READY_LOW != XOSC_STABLE)
        else $error("ready and stable apart");
    AST_DROP: assert property (!XOSC_SETTLED |=> CHIP_READY_LOW)
        else $error("ready kept without oscillator");
    AST_EARLY: assert property (scnt < tgt |-> CHIP_READY_LOW)
        else $error("ready too early");
    AST_LATE: assert property (scnt == tgt |-> !CHIP_READY_LOW)
        else $error("ready too late");
    AST_KEEP: assert property (XOSC_KEEP_ON == zero[0])
        else $error("keep-on bit wrong");

    cover property (CAL_START && $past(AUTO_IDLE));
    cover property (NEXT_VALID && NEXT_STATE == 2'h3);
    cover property ($fell(CHIP_READY_LOW));
endmodule

bind radio_state_config radio_state_config_checker radio_state_config_checker_inst (
    .CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WRITE(REG_WRITE), .RSSI_BELOW(RSSI_BELOW), .RX_PACKET(RX_PACKET),
    .CLEAR_CHANNEL_FLAG(CLEAR_CHANNEL_FLAG), .RX_DONE(RX_DONE), .TX_DONE(TX_DONE),
    .NEXT_VALID(NEXT_VALID), .NEXT_STATE(NEXT_STATE), .CALIBRATE_STROBE(CALIBRATE_STROBE),
    .LEAVE_IDLE(LEAVE_IDLE), .AUTO_IDLE(AUTO_IDLE), .CAL_START(CAL_START),
    .XOSC_SETTLED(XOSC_SETTLED), .CHIP_READY_LOW(CHIP_READY_LOW),
    .XOSC_STABLE(XOSC_STABLE), .XOSC_KEEP_ON(XOSC_KEEP_ON));
`default_nettype wire

// file: sim/host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Host side of the register port
// ********
module host_model
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic      [5:0] addr,
    output logic      [7:0] wdata,
    output logic            write
);
    // Idle bus parks on an unmapped place
    initial
    begin
        addr = 6'h3f;
        wdata = 8'h00;
        write = 1'b0;
    end
    // One-cycle strobe, then a gap; timeout choice is the host's
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        write <= 1'b1;
        @(posedge clk);
        write <= 1'b0;
        wdata <= ~v;
        @(posedge clk);
    endtask
    // Read data lags the address by one edge
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        addr <= a;
        repeat (2) @(posedge clk);
        v = rdata;
    endtask
endmodule
`default_nettype wire

// file: sim/radio_state_config_test.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Bench top
// ********
module radio_state_config_test
    import radio_fsm_pkg::*;
;
    logic       clk, rst_b, rssi, rxp, rxd, txd, calibrate_strobe, leave, auto_i, settled, k;
    logic       write, ccf, nv, cal, rdy_b, stab, keep;
    logic [1:0] nst;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [1:0] q_nx[$];
    logic       q_cal[$];
    int         failures = 0, cmp_count = 0, n;
    int         seed = 32'hcd8789f9;
    logic [5:0] ra[4] = '{6'h16, 6'h17, 6'h18, 6'h3f};
    logic [7:0] rv[4] = '{8'h07, 8'h30, 8'h04, 8'h00};
    logic [7:0] wv[4] = '{8'h1f, 8'h3f, 8'h3f, 8'h00};

    host_model host_model_inst (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .write(write));
    radio_state_config radio_state_config_inst (
        .CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WRITE(write),
        .REG_RDATA(rdata), .RSSI_BELOW(rssi), .RX_PACKET(rxp), .CLEAR_CHANNEL_FLAG(ccf),
        .RX_DONE(rxd), .TX_DONE(txd), .NEXT_VALID(nv), .NEXT_STATE(nst),
        .CALIBRATE_STROBE(calibrate_strobe), .LEAVE_IDLE(leave), .AUTO_IDLE(auto_i), .CAL_START(cal),
        .XOSC_SETTLED(settled), .CHIP_READY_LOW(rdy_b), .XOSC_STABLE(stab),
        .XOSC_KEEP_ON(keep));

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0, got}, {15'h0, exp});
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Clock, 50 ns period
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Whole run is about 22k cycles; allow well over that
    initial
    begin
        #(50 * 40000);
        failures++;
        results;
    end
    // Pulses matched against the oldest note; X or extra pulses fail
    always @(posedge clk)
    begin
        if (rst_b === 1'b1 && nv !== 1'b0)
            chk_val(nst, q_nx.size() > 0 ? q_nx.pop_front() : 2'bxx);
        if (rst_b === 1'b1 && cal !== 1'b0)
            chk_bit(cal, q_cal.size() > 0 ? q_cal.pop_front() : 1'b0);
    end

    // Main sequence
    initial
    begin
        {rst_b, rssi, rxp, rxd, txd, calibrate_strobe, leave, auto_i, settled} = '0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // Reset contents, then unused bits and the unmapped place
        for (int i = 0; i < 4; i++)
        begin
            host_model_inst.rd(ra[i], d);
            chk_val(d, rv[i]);
            host_model_inst.wr(ra[i], 8'hff);
            host_model_inst.rd(ra[i], d);
            chk_val(d, wv[i]);
        end
        // Every clear channel mode under random inputs
        for (int m = 0; m < 4; m++)
        begin
            host_model_inst.wr(6'h17, 8'(m << 4));
            repeat (8)
            begin
                {rssi, rxp} <= 2'($random(seed));
                repeat (2) @(posedge clk);
                chk_bit(ccf, (!m[0] || rssi) && (!m[1] || !rxp));
            end
        end
        // Receive, send, then both at once; receive must win
        for (int i = 0; i < 4; i++)
        begin
            host_model_inst.wr(6'h17, 8'({i[1:0], 2'(3 - i)}));
            q_nx.push_back(2'(i));
            q_nx.push_back(2'(3 - i));
            q_nx.push_back(2'(i));
            rxd <= 1'b1;
            @(posedge clk);
            rxd <= 1'b0;
            txd <= 1'b1;
            @(posedge clk);
            rxd <= 1'b1;
            @(posedge clk);
            {rxd, txd} <= 2'b00;
            repeat (2) @(posedge clk);
        end
        // Each policy sees a strobe, a leave and five automatic returns
        for (int p = 0; p < 4; p++)
        begin
            host_model_inst.wr(6'h18, 8'(p << 4));
            repeat (1 + (p == 1) + 5 * (p == 2) + (p == 3)) q_cal.push_back(1'b1);
            calibrate_strobe <= 1'b1;
            @(posedge clk);
            calibrate_strobe <= 1'b0;
            leave <= 1'b1;
            @(posedge clk);
            leave <= 1'b0;
            auto_i <= 1'b1;
            repeat (5) @(posedge clk);
            auto_i <= 1'b0;
            repeat (2) @(posedge clk);
        end
        // Every timeout setting, measured from oscillator settle
        for (int s = 0; s < 4; s++)
        begin
            k = 1'($random(seed));
            host_model_inst.wr(6'h18, 8'({s[1:0], 1'b0, k}));
            chk_bit(keep, k);
            settled <= 1'b1;
            n = 0;
            while (rdy_b !== 1'b0 && n < 20000)
            begin
                @(posedge clk);
                n++;
            end
            chk_val(16'(n - 1), 16'(64 << (s * 2 + (s > 0) * 2)));
            chk_bit(stab, 1'b1);
            settled <= 1'b0;
            repeat (2) @(posedge clk);
            chk_bit(rdy_b, 1'b1);
        end
        chk_val(16'(q_nx.size() + q_cal.size()), 16'h0);
        results;
    end
endmodule
`default_nettype wire
